// ---- include/audio_port_ctrl_pkg.sv ----
// Constants and carrier types for the first audio port slot tristate
// and clock pin control block. Assumes a byte-wide register port.
`default_nettype none
package audio_port_ctrl_pkg;
   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 8;
   localparam logic [7:0]  OFF_SLOT_TRI     = 8'h09;
   localparam logic [7:0]  OFF_PIN_CTRL     = 8'h0a;
   localparam logic [7:0]  OFF_DIV_SEL      = 8'h0b;
   localparam logic [7:0]  RST_SLOT_TRI     = 8'h00;
   localparam logic [7:0]  RST_PIN_CTRL     = 8'h00;
   localparam logic [7:0]  RST_DIV_SEL      = 8'h00;
   // Field positions
   localparam int          LEFT_HI          = 7;
   localparam int          LEFT_LO          = 4;
   localparam int          RIGHT_HI         = 3;
   localparam int          RIGHT_LO         = 0;
   localparam int          FRAME_DIR_HI     = 7;
   localparam int          FRAME_DIR_LO     = 5;
   localparam int          SER_DIR_HI       = 4;
   localparam int          SER_DIR_LO       = 2;
   localparam int          POL_BIT          = 1;
   localparam int          BUF_PWR_BIT      = 0;
   localparam int          REC_SER_OWN_BIT  = 7;
   localparam int          REC_FRM_OWN_BIT  = 6;
   localparam int          MUX_HI           = 3;
   localparam int          MUX_LO           = 0;
   localparam logic [7:0]  DIV_SEL_WMASK    = 8'hcf;
   localparam logic [2:0]  DIR_INPUT        = 3'h0;
   localparam logic [2:0]  DIR_OUTPUT       = 3'h1;
   localparam logic [3:0]  MUX_LAST_LEGAL   = 4'h8;
   localparam int          NSRC             = 9;

   // Divider input sources
   typedef enum logic [3:0] {
      SRC_PLAY_CLK    = 4'b0000,
      SRC_PLAY_MOD    = 4'b0001,
      SRC_REC_CLK     = 4'b0010,
      SRC_REC_MOD     = 4'b0011,
      SRC_OWN_PIN     = 4'b0100,
      SRC_PORT2_PIN   = 4'b0101,
      SRC_PORT3_PIN   = 4'b0110,
      SRC_REC2_PIN    = 4'b0111,
      SRC_REC3_PIN    = 4'b1000
   } div_src_t;

   // Register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   // Pin control outputs
   typedef struct packed {
      logic       frame_clock_pin_oe;
      logic       serial_clock_pin_oe;
      logic       serial_clock_invert;
      logic       clock_buffers_on;
   } pin_ctrl_t;
endpackage
`default_nettype wire

// ---- logic/audio_port_slot_tristate_clock_ctrl.sv ----
// Register block and control logic for the first audio port: record slot
// tristates, clock pin direction, polarity, buffer power and divider mux.
// Assumes register port inputs are synchronous to clk.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module audio_port_slot_tristate_clock_ctrl
   import audio_port_ctrl_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire reg_req_t          req,
   output var  logic [DATA_W-1:0] rdata,
   input  wire logic              global_output_tristate_enable,
   input  wire logic              multi_pin_mode,
   input  wire logic              codec_powered,
   input  wire logic              port_active,
   input  wire logic              six_wire_mode,
   input  wire logic [3:0]        main_serial_clock_output,
   input  wire logic [3:0]        main_frame_clock_output,
   input  wire logic [3:0]        own_serial_clock_output,
   input  wire logic [3:0]        own_frame_clock_output,
   input  wire logic [NSRC-1:0]   source_clocks,
   output var  logic [7:0]        slot_hiz,
   output var  pin_ctrl_t         pins,
   output var  logic [3:0]        record_serial_clock_output,
   output var  logic [3:0]        record_frame_clock_output,
   output var  logic              serial_divider_input
);

   // Whole state of the block
   typedef struct packed {
      logic [7:0]        slot_tri;
      logic [7:0]        pin_ctrl;
      logic [7:0]        div_sel;
      logic [DATA_W-1:0] rdata;
      logic [7:0]        slot_hiz;
      pin_ctrl_t         pins;
      logic [3:0]        rec_ser;
      logic [3:0]        rec_frm;
      logic              div_in;
   } state_t;

   state_t state;
   state_t next_state;
   logic   rst_meta_n;
   logic   rst_sync_n;

   // Direction decode shared by both clock pins
   function automatic logic drives_pin(input logic [2:0] code);
      return code == DIR_OUTPUT;
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // Next state
   always_comb begin
      logic [3:0] mux;
      logic       left_all;
      logic       right_all;
      mux        = state.div_sel[MUX_HI:MUX_LO];
      left_all   = multi_pin_mode && state.slot_tri[LEFT_LO];
      right_all  = multi_pin_mode && state.slot_tri[RIGHT_LO];
      next_state = state;
      // Register writes
      if (req.wr) begin
         unique case (req.addr)
            OFF_SLOT_TRI: begin
               next_state.slot_tri = req.wdata;
            end
            OFF_PIN_CTRL: begin
               next_state.pin_ctrl = req.wdata;
            end
            OFF_DIV_SEL: begin
               next_state.div_sel = req.wdata & DIV_SEL_WMASK;
            end
            default: begin
            end
         endcase
      end
      // Register reads, data next cycle, zero when unmapped
      next_state.rdata = '0;
      if (req.rd) begin
         unique case (req.addr)
            OFF_SLOT_TRI: begin
               next_state.rdata = state.slot_tri;
            end
            OFF_PIN_CTRL: begin
               next_state.rdata = state.pin_ctrl;
            end
            OFF_DIV_SEL: begin
               next_state.rdata = state.div_sel;
            end
            default: begin
               next_state.rdata = '0;
            end
         endcase
      end
      // Slot tristates gated by global enable
      next_state.slot_hiz = '0;
      if (global_output_tristate_enable) begin
         next_state.slot_hiz = state.slot_tri;
         if (left_all) begin
            next_state.slot_hiz[LEFT_HI:LEFT_LO] = '1;
         end
         if (right_all) begin
            next_state.slot_hiz[RIGHT_HI:RIGHT_LO] = '1;
         end
      end
      // Pin direction, polarity, buffer power
      next_state.pins.frame_clock_pin_oe =
         drives_pin(state.pin_ctrl[FRAME_DIR_HI:FRAME_DIR_LO]);
      next_state.pins.serial_clock_pin_oe =
         drives_pin(state.pin_ctrl[SER_DIR_HI:SER_DIR_LO]);
      next_state.pins.serial_clock_invert = state.pin_ctrl[POL_BIT];
      next_state.pins.clock_buffers_on =
         state.pin_ctrl[BUF_PWR_BIT] || (codec_powered && port_active);
      // Record clock output selections
      next_state.rec_ser = main_serial_clock_output;
      next_state.rec_frm = main_frame_clock_output;
      if (six_wire_mode && state.div_sel[REC_SER_OWN_BIT]) begin
         next_state.rec_ser = own_serial_clock_output;
      end
      if (six_wire_mode && state.div_sel[REC_FRM_OWN_BIT]) begin
         next_state.rec_frm = own_frame_clock_output;
      end
      // Divider input mux, reserved codes give a quiet low
      if (mux <= MUX_LAST_LEGAL) begin
         next_state.div_in = source_clocks[mux];
      end else begin
         next_state.div_in = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state          <= '0;
         state.slot_tri <= RST_SLOT_TRI;
         state.pin_ctrl <= RST_PIN_CTRL;
         state.div_sel  <= RST_DIV_SEL;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from flops
   assign rdata                      = state.rdata;
   assign slot_hiz                   = state.slot_hiz;
   assign pins                       = state.pins;
   assign record_serial_clock_output = state.rec_ser;
   assign record_frame_clock_output  = state.rec_frm;
   assign serial_divider_input       = state.div_in;

   // Checks: slot tristate gating and mapping
   chk_slot_gate: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      !global_output_tristate_enable |=> slot_hiz == '0)
      else $error("slot tristate active without global enable");
   chk_slot_map: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      global_output_tristate_enable && !multi_pin_mode
      |=> slot_hiz == $past(state.slot_tri))
      else $error("slot tristate map wrong");
   chk_slot_write: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      req.wr && req.addr == OFF_SLOT_TRI
      |=> state.slot_tri == $past(req.wdata))
      else $error("slot tristate write lost");
   chk_left_all: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      global_output_tristate_enable && multi_pin_mode
      && state.slot_tri[LEFT_LO] |=> slot_hiz[LEFT_HI:LEFT_LO] == 4'hf)
      else $error("left group not tristated");
   chk_right_all: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      global_output_tristate_enable && multi_pin_mode
      && state.slot_tri[RIGHT_LO] |=> slot_hiz[RIGHT_HI:RIGHT_LO] == 4'hf)
      else $error("right group not tristated");

   // Checks: clock pin direction, polarity and buffer power
   chk_frame_dir: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      req.wr && req.addr == OFF_PIN_CTRL |=> ##1 pins.frame_clock_pin_oe
      == ($past(req.wdata[FRAME_DIR_HI:FRAME_DIR_LO], 2) == DIR_OUTPUT))
      else $error("frame clock direction wrong");
   chk_ser_dir: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      req.wr && req.addr == OFF_PIN_CTRL |=> ##1 pins.serial_clock_pin_oe
      == ($past(req.wdata[SER_DIR_HI:SER_DIR_LO], 2) == DIR_OUTPUT))
      else $error("serial clock direction wrong");
   chk_polarity: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      ##1 pins.serial_clock_invert == $past(state.pin_ctrl[POL_BIT]))
      else $error("polarity wrong");
   chk_buf_power: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      !state.pin_ctrl[BUF_PWR_BIT] && !codec_powered
      |=> !pins.clock_buffers_on)
      else $error("buffers on while codec down");
   chk_buf_keep: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      state.pin_ctrl[BUF_PWR_BIT] |=> pins.clock_buffers_on)
      else $error("buffers off although held on");

   // Checks: record clock output selections
   chk_rec_ser: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      !state.div_sel[REC_SER_OWN_BIT] |=> record_serial_clock_output
      == $past(main_serial_clock_output))
      else $error("record serial clock not copied");
   chk_rec_frm: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      !state.div_sel[REC_FRM_OWN_BIT] |=> record_frame_clock_output
      == $past(main_frame_clock_output))
      else $error("record frame clock not copied");
   chk_rec_ser_own: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      six_wire_mode && state.div_sel[REC_SER_OWN_BIT]
      |=> record_serial_clock_output == $past(own_serial_clock_output))
      else $error("record serial clock own selection wrong");
   chk_rec_frm_own: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      six_wire_mode && state.div_sel[REC_FRM_OWN_BIT]
      |=> record_frame_clock_output == $past(own_frame_clock_output))
      else $error("record frame clock own selection wrong");

   // Checks: divider input source
   chk_mux_play: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      state.div_sel[MUX_HI:MUX_LO] == SRC_PLAY_CLK
      |=> serial_divider_input == $past(source_clocks[SRC_PLAY_CLK]))
      else $error("divider input not playback clock");
   chk_mux_rec: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      state.div_sel[MUX_HI:MUX_LO] == SRC_REC_CLK
      |=> serial_divider_input == $past(source_clocks[SRC_REC_CLK]))
      else $error("divider input not record clock");
   chk_mux_port2: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      state.div_sel[MUX_HI:MUX_LO] == SRC_PORT2_PIN
      |=> serial_divider_input == $past(source_clocks[SRC_PORT2_PIN]))
      else $error("divider input not port 2 pin");
   chk_mux_own: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      state.div_sel[MUX_HI:MUX_LO] == SRC_OWN_PIN
      |=> serial_divider_input == $past(source_clocks[SRC_OWN_PIN]))
      else $error("divider input not own pin");
   chk_mux_rec_pin: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      state.div_sel[MUX_HI:MUX_LO] == SRC_REC3_PIN
      |=> serial_divider_input == $past(source_clocks[SRC_REC3_PIN]))
      else $error("divider input not record pin");
   chk_mux_resv: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      state.div_sel[MUX_HI:MUX_LO] > MUX_LAST_LEGAL
      |=> !serial_divider_input)
      else $error("reserved divider code not quiet");

   // Checks: register port reserved bits
   chk_resv_zero: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      req.rd && req.addr == OFF_DIV_SEL |=> rdata[5:4] == 2'h0)
      else $error("reserved bits read nonzero");
   chk_resv_write: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      req.wr && req.addr == OFF_DIV_SEL
      |=> state.div_sel == ($past(req.wdata) & DIV_SEL_WMASK))
      else $error("reserved bits stored nonzero");

   // Main scenarios
   cov_multi_left: cover property (@(posedge clk) disable iff (!rst_sync_n)
      slot_hiz[LEFT_HI:LEFT_LO] == 4'hf && multi_pin_mode);
   cov_frame_out: cover property (@(posedge clk) disable iff (!rst_sync_n)
      pins.frame_clock_pin_oe);
   cov_rec_own: cover property (@(posedge clk) disable iff (!rst_sync_n)
      six_wire_mode && state.div_sel[REC_SER_OWN_BIT]);
   cov_read_back: cover property (@(posedge clk) disable iff (!rst_sync_n)
      req.rd && req.addr == OFF_SLOT_TRI ##1 rdata != 8'h00);
   cov_mux_resv: cover property (@(posedge clk) disable iff (!rst_sync_n)
      state.div_sel[MUX_HI:MUX_LO] > MUX_LAST_LEGAL);

endmodule
`default_nettype wire

// ---- testbench/host_port_model.sv ----
// Far side model: host serial port supplying external clocks and activity.
// Assumes the bench sets the requested levels just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
   input  wire logic       clk,
   input  wire logic [8:0] pattern,
   input  wire logic       want_active,
   output var  logic [8:0] src,
   output var  logic       active
);
   // Host changes its pins only after a clock edge
   always @(posedge clk) begin
      src    <= pattern;
      active <= want_active;
   end
endmodule
`default_nettype wire

// ---- testbench/audio_port_slot_tristate_clock_ctrl_tb.sv ----
// Self-checking bench: random register traffic against a register model.
// Assumes the package constants and the host port model file.
`timescale 1ns/100ps
`default_nettype none
module audio_port_slot_tristate_clock_ctrl_tb
   import audio_port_ctrl_pkg::*;
;
   logic       clk, rst_n, gte, multi, codec, six, want_act, port_active;
   logic       sdi;
   reg_req_t   req;
   pin_ctrl_t  pins;
   logic [7:0] rdata, slot_hiz;
   logic [3:0] ms, mf, os, of_, rso, rfo;
   logic [8:0] pat, src;
   logic [31:0] seed;
   logic [7:0] m [3];
   int         mismatches, num_checks, cycles;

   audio_port_slot_tristate_clock_ctrl uut (
      .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
      .global_output_tristate_enable(gte), .multi_pin_mode(multi),
      .codec_powered(codec), .port_active(port_active),
      .six_wire_mode(six), .main_serial_clock_output(ms),
      .main_frame_clock_output(mf), .own_serial_clock_output(os),
      .own_frame_clock_output(of_), .source_clocks(src),
      .slot_hiz(slot_hiz), .pins(pins),
      .record_serial_clock_output(rso), .record_frame_clock_output(rfo),
      .serial_divider_input(sdi));

   host_port_model partner (.clk(clk), .pattern(pat),
      .want_active(want_act), .src(src), .active(port_active));

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction

   function automatic logic [7:0] mreg(input logic [7:0] a);
      return (a >= OFF_SLOT_TRI && a <= OFF_DIV_SEL) ?
             m[a - OFF_SLOT_TRI] : 8'h00;
   endfunction

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe; model keeps the written byte, masked for the divider select
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
      if (a >= OFF_SLOT_TRI && a <= OFF_DIV_SEL)
         m[a - OFF_SLOT_TRI] = (a == OFF_DIV_SEL) ? d & DIV_SEL_WMASK : d;
   endtask

   // One-cycle read strobe; data checked in the following cycle
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk(rdata, mreg(a));
   endtask

   // Let writes and input changes settle, then compare every output except rdata
   task automatic cmp_outs;
      logic [7:0] e;
      logic [3:0] s;
      logic [3:0] code;
      repeat (4) @(posedge clk);
      #1;
      e = multi ? {{4{m[0][4]}}, {4{m[0][0]}}} : m[0];
      chk(slot_hiz, gte ? e : 8'h00);
      s = {m[1][7:5] == DIR_OUTPUT, m[1][4:2] == DIR_OUTPUT, m[1][1],
           m[1][0] | (codec & want_act)};
      chk({4'h0, pins}, {4'h0, s});
      chk({rso, rfo}, {six & m[2][7] ? os : ms,
                       six & m[2][6] ? of_ : mf});
      code = m[2][3:0];
      chk({7'h0, sdi},
          {7'h0, code <= MUX_LAST_LEGAL && pat[code]});
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         close_out();
      end
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      req = '0;
      {gte, multi, codec, six, want_act} = 5'h00;
      {ms, mf, os, of_} = 16'h0000;
      pat = 9'h000;
      seed = 32'h3fe0;
      m = '{8'h00, 8'h00, 8'h00};
      mismatches = 0;
      num_checks = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 8; a < 13; a++) rd(a[7:0]);
      cmp_outs();
      for (int i = 0; i < 64; i++) begin
         seed = lfsr(seed);
         @(posedge clk);
         {six, codec, want_act, gte, multi} <= seed[4:0];
         {ms, mf, os, of_} <= seed[31:16];
         pat <= seed[13:5];
         wr(OFF_SLOT_TRI, seed[0] ? seed[23:16] & 8'h11 : seed[23:16]);
         wr(OFF_PIN_CTRL, {2'h0, seed[8], 2'h0, seed[9], seed[11:10]});
         wr(OFF_DIV_SEL, {seed[31:30], 2'h0, i[3:0]});
         cmp_outs();
         for (int a = 8; a < 13; a++) rd(a[7:0]);
      end
      close_out();
   end
endmodule
`default_nettype wire
